// ==== src/psp_pkg.sv ====
// Purpose: Shared constants and types for the parallel slave byte port.
// Assumes: AHB-Lite register bus with 32-bit data and word-index addressing.
// Notes: Register byte address is four times the register index.
package psp_pkg;

  // Register indexes; byte address is index times four.
  localparam logic [7:0] PSP_IDX_DATA = 8'h08;
  localparam logic [7:0] PSP_IDX_CTL_PORT = 8'h09;
  localparam logic [7:0] PSP_IDX_IRQ_FLAGS = 8'h0C;
  localparam logic [7:0] PSP_IDX_STATUS = 8'h89;
  localparam logic [7:0] PSP_IDX_IRQ_EN = 8'h8C;
  localparam logic [7:0] PSP_IDX_ANALOG = 8'h9F;

  // Field positions.
  localparam int PSP_BIT_IBF = 7;
  localparam int PSP_BIT_OBF = 6;
  localparam int PSP_BIT_INPUT_OVERRUN_FLAG = 5;
  localparam int PSP_BIT_MODE = 4;
  localparam int PSP_BIT_PORT_IRQ = 7;
  localparam int PSP_BIT_ADFM = 7;
  localparam int PSP_BIT_ADCS2 = 6;
  localparam int PSP_PIN_RD = 0;
  localparam int PSP_PIN_WR = 1;
  localparam int PSP_PIN_CS = 2;

  // Reset values.
  localparam logic [2:0] PSP_DIR_RESET = 3'h7;
  localparam logic [2:0] PSP_DIR_ALL_IN = 3'h7;
  localparam logic [7:0] PSP_BYTE_RESET = 8'h00;
  localparam logic [3:0] PSP_PCFG_RESET = 4'h0;

  // Analog configuration code that makes the three control pins digital.
  localparam logic [3:0] PSP_PCFG_DIGITAL = 4'h6;

  // Instruction clock phases, one core clock each.
  localparam logic [1:0] PSP_PHASE_TWO = 2'h1;
  localparam logic [1:0] PSP_PHASE_FOUR = 2'h3;
  localparam logic [1:0] PSP_PHASE_STEP = 2'h1;

  // AHB transfer type bit that marks NONSEQ or SEQ.
  localparam int PSP_HTRANS_ACTIVE = 1;

  // Transfer state machine, one-hot.
  typedef enum logic [4:0] {
    PSP_IDLE = 5'h01,
    PSP_WRITE = 5'h02,
    PSP_READ = 5'h04,
    PSP_WAIT_P2 = 5'h08,
    PSP_WAIT_P4 = 5'h10
  } psp_state_t;

  // Pins seen by the block.
  typedef struct packed {
    logic [7:0] data;
    logic [2:0] ctl;
  } psp_pin_in_t;

  // Pin drive; an enable bit is low while the pin is driven.
  typedef struct packed {
    logic [7:0] data;
    logic [7:0] data_oe_n;
    logic [2:0] ctl;
    logic [2:0] ctl_oe_n;
  } psp_pin_out_t;

  // Whole state of the port.
  typedef struct packed {
    psp_state_t st;
    logic was_write;
    logic [1:0] phase;
    logic [7:0] data_s1;
    logic [7:0] data_s2;
    logic [2:0] ctl_s1;
    logic [2:0] ctl_s2;
    logic [7:0] out_latch;
    logic [7:0] in_latch;
    logic [2:0] ctl_latch;
    logic [2:0] ctl_dir;
    logic mode;
    logic input_full_flag;
    logic output_full_flag;
    logic input_overrun_flag;
    logic irq_flag;
    logic irq_en;
    logic [1:0] adc_misc;
    logic [3:0] pcfg;
    logic wr_pend;
    logic [7:0] wr_idx;
    logic [31:0] rdata;
  } psp_state_s_t;

endpackage

// ==== src/psp_port.sv ====
// Purpose: Parallel slave byte port with an AHB-Lite register slave.
// Assumes: Pins arrive asynchronously; a four-phase instruction clock is
//   derived from hclk, one phase per enabled clock.
// Notes: Strobes are sampled by level after two synchronising flip-flops.
// Notes on behaviour
// - With the enable bit set, data pins form an external-access byte port.
// - Enable turns control pins into read strobe, write strobe, chip select.
// - Strobes act only when all three control direction bits are inputs.
// - Strobes act only when the analog field selects digital pins.
// - One address: firmware writes output latch, reads input latch in port mode and synchronised pins otherwise.
// - In port mode data direction comes only from the external strobes.
// - Select and write strobe first seen low together start a write.
// - Write end sets input-full and irq flag at phase four after phase two.
// - Input-full clears on a firmware read of the data register or with port mode off.
// - Write completing while input-full is set raises the overrun flag.
// - Select and read strobe first seen low clear output-full at once.
// - Read end sets irq flag at phase four after phase two.
// - Output-full stays low until firmware writes the output latch.
// - With port mode off, input-full and output-full are held clear.
// - Overrun flag stays set until firmware writes it to zero.
// - Irq flag holds until cleared; request raised only when enabled.
// - Without the port option, irq flag and enable read as zero.
// - During a selected read the output latch drives the data pins.
// - During a selected write the data pins are captured into input latch.
//
// Decided for this implementation: the AHB-Lite slave port.
`timescale 1ns/100ps
`default_nettype none

module psp_port
  import psp_pkg::*;
#(
  parameter bit HAS_PORT = 1'b1
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic clk_en,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire psp_pin_in_t pin_in,
  output psp_pin_out_t pin_out,
  output logic port_irq
);

  psp_state_s_t s;
  psp_state_s_t next_s;
  logic live;
  logic sel_wr;
  logic sel_rd;
  logic pins_digital;
  logic take;
  logic [7:0] idx;
  logic [7:0] wbyte;
  logic [7:0] rbyte;
  logic hw_fl_set;
  logic hw_ibf_set;
  logic hw_input_overrun_flag_set;
  logic hw_obf_clr;
  logic fw_data_rd;

  // Strobes count only with port mode on and pins set up as digital inputs.
  always_comb begin
    pins_digital = (s.pcfg == PSP_PCFG_DIGITAL);
    live = HAS_PORT && s.mode && pins_digital && (s.ctl_dir == PSP_DIR_ALL_IN);
    sel_wr = live && !s.ctl_s2[PSP_PIN_CS] && !s.ctl_s2[PSP_PIN_WR];
    sel_rd = live && !s.ctl_s2[PSP_PIN_CS] && !s.ctl_s2[PSP_PIN_RD];
  end

  // Bus address phase decode; only words are used, low data byte holds the register.
  always_comb begin
    take = hsel && htrans[PSP_HTRANS_ACTIVE] && hready && clk_en;
    idx = haddr[9:2];
    wbyte = hwdata[7:0];
    fw_data_rd = take && !hwrite && (idx == PSP_IDX_DATA);
  end

  // Read value of the addressed register; unmapped indexes read zero.
  always_comb begin
    rbyte = PSP_BYTE_RESET;
    case (idx)
      PSP_IDX_DATA: begin
        rbyte = s.mode ? s.in_latch : s.data_s2;
      end
      PSP_IDX_CTL_PORT: begin
        rbyte = {5'h00, pins_digital ? s.ctl_s2 : 3'h0};
      end
      PSP_IDX_IRQ_FLAGS: begin
        rbyte[PSP_BIT_PORT_IRQ] = HAS_PORT && s.irq_flag;
      end
      PSP_IDX_STATUS: begin
        rbyte = {s.input_full_flag, s.output_full_flag, s.input_overrun_flag, s.mode, 1'b0, s.ctl_dir};
      end
      PSP_IDX_IRQ_EN: begin
        rbyte[PSP_BIT_PORT_IRQ] = HAS_PORT && s.irq_en;
      end
      PSP_IDX_ANALOG: begin
        rbyte = {s.adc_misc, 2'h0, s.pcfg};
      end
      default: begin
        rbyte = PSP_BYTE_RESET;
      end
    endcase
  end

  // Next state: synchronisers, phase counter, transfer machine, registers.
  always_comb begin
    next_s = s;
    hw_fl_set = 1'b0;
    hw_ibf_set = 1'b0;
    hw_input_overrun_flag_set = 1'b0;
    hw_obf_clr = 1'b0;

    // Pins pass two flops; only the second stage is read by logic.
    next_s.data_s1 = pin_in.data;
    next_s.data_s2 = s.data_s1;
    next_s.ctl_s1 = pin_in.ctl;
    next_s.ctl_s2 = s.ctl_s1;

    // Four-phase instruction clock.
    next_s.phase = s.phase + PSP_PHASE_STEP;

    // Transfer machine, level sensed on the synchronised strobes.
    case (s.st)
      PSP_IDLE: begin
        if (sel_wr) begin
          next_s.st = PSP_WRITE;
          next_s.was_write = 1'b1;
          next_s.in_latch = s.data_s2;
        end else if (sel_rd) begin
          next_s.st = PSP_READ;
          next_s.was_write = 1'b0;
          hw_obf_clr = 1'b1;
        end
      end
      PSP_WRITE: begin
        if (sel_wr) begin
          next_s.in_latch = s.data_s2;
        end else begin
          next_s.st = PSP_WAIT_P2;
        end
      end
      PSP_READ: begin
        if (!sel_rd) begin
          next_s.st = PSP_WAIT_P2;
        end
      end
      PSP_WAIT_P2: begin
        if (s.phase == PSP_PHASE_TWO) begin
          next_s.st = PSP_WAIT_P4;
        end
      end
      PSP_WAIT_P4: begin
        if (s.phase == PSP_PHASE_FOUR) begin
          next_s.st = PSP_IDLE;
          hw_fl_set = 1'b1;
          hw_ibf_set = s.was_write;
          hw_input_overrun_flag_set = s.was_write && s.input_full_flag;
        end
      end
      default: begin
        next_s.st = PSP_IDLE;
      end
    endcase

    // Bus: capture the address phase, perform the write in the data phase.
    next_s.wr_pend = take && hwrite;
    if (take) begin
      next_s.wr_idx = idx;
    end
    if (take && !hwrite) begin
      next_s.rdata = {24'h000000, rbyte};
    end
    if (s.wr_pend) begin
      case (s.wr_idx)
        PSP_IDX_DATA: begin
          next_s.out_latch = wbyte;
          next_s.output_full_flag = 1'b1;
        end
        PSP_IDX_CTL_PORT: begin
          next_s.ctl_latch = wbyte[2:0];
        end
        PSP_IDX_IRQ_FLAGS: begin
          next_s.irq_flag = HAS_PORT && wbyte[PSP_BIT_PORT_IRQ];
        end
        PSP_IDX_STATUS: begin
          next_s.input_overrun_flag = wbyte[PSP_BIT_INPUT_OVERRUN_FLAG];
          next_s.mode = HAS_PORT && wbyte[PSP_BIT_MODE];
          next_s.ctl_dir = wbyte[2:0];
        end
        PSP_IDX_IRQ_EN: begin
          next_s.irq_en = HAS_PORT && wbyte[PSP_BIT_PORT_IRQ];
        end
        PSP_IDX_ANALOG: begin
          next_s.adc_misc = {wbyte[PSP_BIT_ADFM], wbyte[PSP_BIT_ADCS2]};
          next_s.pcfg = wbyte[3:0];
        end
        default: begin
          next_s.ctl_latch = s.ctl_latch;
        end
      endcase
    end

    // Firmware read of the data register clears input-full; set wins.
    if (fw_data_rd) begin
      next_s.input_full_flag = 1'b0;
    end
    if (hw_ibf_set) begin
      next_s.input_full_flag = 1'b1;
    end
    if (hw_obf_clr) begin
      next_s.output_full_flag = 1'b0;
    end
    if (hw_input_overrun_flag_set) begin
      next_s.input_overrun_flag = 1'b1;
    end
    if (hw_fl_set) begin
      next_s.irq_flag = 1'b1;
    end

    // Outside port mode both buffer flags are held clear.
    if (!next_s.mode) begin
      next_s.input_full_flag = 1'b0;
      next_s.output_full_flag = 1'b0;
    end
  end

  // State register; clock enable low freezes everything.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      // Every field is a constant; the transfer machine starts idle.
      s <= '{
        st: PSP_IDLE,
        was_write: 1'b0,
        phase: 2'h0,
        data_s1: PSP_BYTE_RESET,
        data_s2: PSP_BYTE_RESET,
        ctl_s1: 3'h0,
        ctl_s2: 3'h0,
        out_latch: PSP_BYTE_RESET,
        in_latch: PSP_BYTE_RESET,
        ctl_latch: 3'h0,
        // Control pins come out of reset as inputs.
        ctl_dir: PSP_DIR_RESET,
        mode: 1'b0,
        input_full_flag: 1'b0,
        output_full_flag: 1'b0,
        input_overrun_flag: 1'b0,
        irq_flag: 1'b0,
        irq_en: 1'b0,
        adc_misc: 2'h0,
        // Pins start as analog, so strobes are ignored until set up.
        pcfg: PSP_PCFG_RESET,
        wr_pend: 1'b0,
        wr_idx: 8'h00,
        rdata: 32'h00000000
      };
    end else if (clk_en) begin
      s <= next_s;
    end
  end

  // Bus answers: no wait states while enabled, always OKAY.
  assign hreadyout = clk_en;
  assign hresp = 1'b0;
  assign hrdata = s.rdata;

  // Interrupt request only while the enable bit is set.
  assign port_irq = HAS_PORT && s.irq_flag && s.irq_en;

  // Pin drive: in port mode data pins follow only the select and read strobes.
  always_comb begin
    pin_out.data = s.out_latch;
    pin_out.data_oe_n = {8{!(s.st == PSP_READ)}};
    pin_out.ctl = s.ctl_latch;
    pin_out.ctl_oe_n = s.ctl_dir | {3{s.mode}};
  end

endmodule

`default_nettype wire

// ==== tb/psp_port_sva.sv ====
// Purpose: Port assertions for the byte port.
// Assumes: clk_en is held high.
// Notes: Strobes need two sync flops and one state edge.
`timescale 1ns/100ps
`default_nettype none
module psp_port_sva
  import psp_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic clk_en,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic [31:0] hrdata,
  input wire psp_pin_in_t pin_in,
  input wire psp_pin_out_t pin_out,
  input wire logic port_irq
);
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);
  // Bus side: zero wait states, byte-wide read data held between reads.
  ready_follow_a: assert property (hreadyout == clk_en && !hresp)
    else $error("bus answer wrong");
  rdata_upper_a: assert property (hrdata[31:8] == 24'h0)
    else $error("read data upper bits set");
  rdata_hold_a: assert property (!(hsel && htrans[1] && hready && !hwrite) |=> $stable(hrdata))
    else $error("read data moved");
  // Pin side: drive only for a selected read, all bits together.
  read_drive_a: assert property (
    $fell(pin_out.data_oe_n[0]) |-> !$past(pin_in.ctl[0], 3) && !$past(pin_in.ctl[2], 3))
    else $error("drive without read");
  read_release_a: assert property (
    $rose(pin_out.data_oe_n[0]) |-> $past(pin_in.ctl[0], 3) || $past(pin_in.ctl[2], 3))
    else $error("drive released early");
  drive_width_a: assert property (pin_out.data_oe_n inside {8'h00, 8'hFF})
    else $error("partial data drive");
  drive_stable_a: assert property (!pin_out.data_oe_n[0] [*2] |-> $stable(pin_out.data))
    else $error("driven byte changed");
  // A request rises only after a transfer ended.
  irq_after_a: assert property ($rose(port_irq) |-> $past(pin_in.ctl[2], 3))
    else $error("request too early");
  cover property ($fell(pin_out.data_oe_n[0]));
  cover property ($rose(port_irq));
  cover property (hsel && htrans[1] && !hwrite);
endmodule
`default_nettype wire

// ==== tb/psp_ext_model.sv ====
// Purpose: External processor on the byte port pins.
// Assumes: Strobes low 6 cycles, high 12.
// Notes: A released data line shows the inverse of the last byte.
`timescale 1ns/100ps
`default_nettype none
module psp_ext_model
  import psp_pkg::*;
(
  input wire logic hclk,
  input wire psp_pin_out_t pin_out,
  output var psp_pin_in_t pin_in
);
  logic [7:0] drv = 8'h00;
  logic [2:0] ctl = 3'h7;
  // Each data bit follows the device where it drives, else this side.
  assign pin_in.data = (pin_out.data & ~pin_out.data_oe_n) | (drv & pin_out.data_oe_n);
  assign pin_in.ctl = ctl;
  // Select and write strobe fall together with the byte.
  task automatic ext_write(input logic [7:0] b);
    drv <= b;
    ctl <= 3'h1;
    repeat (6) @(posedge hclk);
    ctl <= 3'h7;
    drv <= ~b;
    repeat (12) @(posedge hclk);
  endtask
  // Select and read strobe fall; the byte is taken before release.
  task automatic ext_read(output logic [7:0] b);
    ctl <= 3'h2;
    repeat (6) @(posedge hclk);
    b = pin_in.data;
    ctl <= 3'h7;
    repeat (12) @(posedge hclk);
  endtask
endmodule
`default_nettype wire

// ==== tb/test_psp_port.sv ====
// Purpose: Self-checking bench for the byte port.
// Assumes: Single AHB-Lite master, word transfers.
// Notes: Each scenario is its own task.
`timescale 1ns/100ps
`default_nettype none
module test_psp_port;
  import psp_pkg::*;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic clk_en = 1'b1;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic hready;
  logic hreadyout;
  logic hresp;
  logic [31:0] hrdata;
  logic port_irq;
  psp_pin_in_t pin_in;
  psp_pin_out_t pin_out;
  int err_total = 0;
  int checked = 0;
  int cyc = 0;
  logic [7:0] b;
  assign hready = hreadyout;
  always #20 hclk = ~hclk;
  psp_port dut_u (.hclk(hclk), .hresetn(hresetn), .clk_en(clk_en), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .pin_in(pin_in),
    .pin_out(pin_out), .port_irq(port_irq));
  psp_ext_model model_u (.hclk(hclk), .pin_out(pin_out), .pin_in(pin_in));
  // Verdict and end of run.
  task automatic tally_and_finish();
    $display("Checks %0d errors %0d", checked, err_total);
    if (err_total == 0 && checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic check(input string n, input logic [31:0] s, input logic [31:0] e);
    checked++;
    if (s !== e) begin
      $display("Error %s expected %h seen %h", n, e, s);
      err_total++;
    end
  endtask
  // One transfer; address held until hready, then data phase until hready.
  task automatic bus(input logic w, input logic [7:0] i, input logic [31:0] d,
    output logic [31:0] q);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {22'h0, i, 2'h0};
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
    q = hrdata;
  endtask
  task automatic wr(input logic [7:0] i, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, i, d, q);
  endtask
  task automatic rc(input string n, input logic [7:0] i, input logic [31:0] e);
    logic [31:0] q;
    bus(1'b0, i, 32'h0, q);
    check(n, q, e);
  endtask
  task automatic s_reset();
    rc("status", PSP_IDX_STATUS, 32'h07);
    rc("flags", PSP_IDX_IRQ_FLAGS, 32'h00);
    rc("enables", PSP_IDX_IRQ_EN, 32'h00);
    wr(8'h40, 32'hFF);
    rc("unmapped", 8'h40, 32'h00);
  endtask
  // Strobes ignored until the pins are digital; then output latch set.
  task automatic s_setup();
    wr(PSP_IDX_STATUS, 32'h17);
    check("ctl drive", {29'h0, pin_out.ctl_oe_n}, 32'h7);
    model_u.ext_write(8'h11);
    rc("status", PSP_IDX_STATUS, 32'h17);
    wr(PSP_IDX_ANALOG, {28'h0, PSP_PCFG_DIGITAL});
    wr(PSP_IDX_IRQ_EN, 32'h80);
    wr(PSP_IDX_DATA, 32'hA5);
    rc("status", PSP_IDX_STATUS, 32'h57);
  endtask
  task automatic s_read();
    model_u.ext_read(b);
    check("pins", {24'h0, b}, 32'hA5);
    rc("status", PSP_IDX_STATUS, 32'h17);
    rc("flags", PSP_IDX_IRQ_FLAGS, 32'h80);
    check("irq", {31'h0, port_irq}, 32'h1);
    wr(PSP_IDX_IRQ_FLAGS, 32'h00);
    @(posedge hclk);
    check("irq", {31'h0, port_irq}, 32'h0);
  endtask
  // Two writes overrun; flag writes leave input-full; a data read clears it.
  task automatic s_write();
    model_u.ext_write(8'h3C);
    rc("status", PSP_IDX_STATUS, 32'h97);
    rc("flags", PSP_IDX_IRQ_FLAGS, 32'h80);
    model_u.ext_write(8'hC3);
    rc("status", PSP_IDX_STATUS, 32'hB7);
    wr(PSP_IDX_STATUS, 32'h37);
    rc("status", PSP_IDX_STATUS, 32'hB7);
    wr(PSP_IDX_IRQ_EN, 32'h00);
    @(posedge hclk);
    check("irq", {31'h0, port_irq}, 32'h0);
    rc("data", PSP_IDX_DATA, 32'hC3);
    rc("status", PSP_IDX_STATUS, 32'h37);
    wr(PSP_IDX_STATUS, 32'h27);
    rc("status", PSP_IDX_STATUS, 32'h27);
    wr(PSP_IDX_STATUS, 32'h07);
    rc("status", PSP_IDX_STATUS, 32'h07);
  endtask
  initial begin
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    s_reset();
    s_setup();
    s_read();
    s_write();
    tally_and_finish();
  end
  // Hang guard.
  always @(posedge hclk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      err_total++;
      tally_and_finish();
    end
  end
endmodule
bind psp_port psp_port_sva chk_u (.hclk(hclk), .hresetn(hresetn), .clk_en(clk_en), .hsel(hsel),
  .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
  .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .pin_in(pin_in),
  .pin_out(pin_out), .port_irq(port_irq));
`default_nettype wire
